// ==== design/nfc_map.vh ====
// Constants of the NAND host controller: command codes, ops, timing.
// Assumes a 10 ns clock; counts are derived from the times below.
`ifndef NFC_MAP_VH
`define NFC_MAP_VH

`define NFC_CLK_NS 10
`define NFC_CYC_MIN(ns) (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

// Strobe phases and waits, least times in ns
`define NFC_T_WP_NS 12
`define NFC_T_WH_NS 10
`define NFC_T_REA_NS 20
`define NFC_T_REH_NS 10
`define NFC_T_WB_NS 100
`define NFC_T_WW_NS 100

// Command codes of the defined set
`define NFC_CMD_READ1 8'h00
`define NFC_CMD_READ2 8'h30
`define NFC_CMD_PROG1 8'h80
`define NFC_CMD_PROG2 8'h10
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hd0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_RESET 8'hff

// User operations
`define NFC_OP_RESET 3'h0
`define NFC_OP_STATUS 3'h1
`define NFC_OP_READ 3'h2
`define NFC_OP_PROG 3'h3
`define NFC_OP_ERASE 3'h4
`define NFC_OP_BADCHK 3'h5

// Status byte fields
`define NFC_ST_FAIL_BIT 0
`define NFC_ST_READY_BIT 6

// Address layout
`define NFC_COL_W 12
`define NFC_PAGE_W 6
`define NFC_ADDR_CYCLES 3'h5
`define NFC_ROW_FIRST 3'h2

// Usage limits
`define NFC_BAD_MARK 8'h00
`define NFC_PARTIAL_MAX 3'h4
`define NFC_ECC_MASK 9'h1ff
`define NFC_BLOCKS 2048
`define NFC_BLK_W 11

`endif

// ==== design/nfc_fifo.v ====
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock and an active-low reset already synchronised.
module nfc_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // nfc_fifo

// ==== design/nfc_host.v ====
// Host controller for a parallel NAND flash on a multiplexed I/O bus.
// Assumes pin inputs synchronous to clk and an external ready/busy pull-up.
`include "nfc_map.vh"
module nfc_host #(
  parameter BLOCKS = `NFC_BLOCKS,
  parameter BLK_W = `NFC_BLK_W,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire nrst,
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [2:0] cmd_op,
  input wire [BLK_W-1:0] cmd_block,
  input wire [5:0] cmd_page,
  input wire [11:0] cmd_col,
  input wire [11:0] cmd_len,
  input wire [7:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg rd_chunk_end,
  output reg done,
  output reg done_fail,
  output reg done_refused,
  output reg [7:0] done_status,
  output reg block_bad,
  output reg ce_n,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg output_strobe_n,
  output reg wp_n,
  output reg [7:0] io_out,
  output reg io_oe,
  input wire [7:0] io_in,
  input wire ready_busy_out
);
  // Counts worked out as integers, cut to the timer width on purpose
  localparam WLO_N = `NFC_CYC_MIN(`NFC_T_WP_NS);
  localparam WHI_N = `NFC_CYC_MIN(`NFC_T_WH_NS);
  localparam RLO_N = `NFC_CYC_MIN(`NFC_T_REA_NS) + 1;
  localparam RHI_N = `NFC_CYC_MIN(`NFC_T_REH_NS);
  localparam TWB_N = `NFC_CYC_MIN(`NFC_T_WB_NS);
  localparam TWW_N = `NFC_CYC_MIN(`NFC_T_WW_NS);
  localparam [7:0] WLO = WLO_N[7:0];
  localparam [7:0] WHI = WHI_N[7:0];
  localparam [7:0] RLO = RLO_N[7:0];
  localparam [7:0] RHI = RHI_N[7:0];
  localparam [7:0] TWB = TWB_N[7:0];
  localparam [7:0] TWW = TWW_N[7:0];

  localparam [2:0] ST_IDLE = 3'h0, ST_SEQ = 3'h1, ST_WLO = 3'h2,
    ST_WHI = 3'h3, ST_RLO = 3'h4, ST_RHI = 3'h5, ST_DLY = 3'h6,
    ST_BUSY = 3'h7;
  localparam [3:0] Q_C1 = 4'h0, Q_AD = 4'h1, Q_WD = 4'h2, Q_C2 = 4'h3,
    Q_BSY = 4'h4, Q_SC = 4'h5, Q_SR = 4'h6, Q_RD = 4'h7, Q_FIN = 4'h8;

  reg rs1_reg;
  reg rst_n;
  reg [2:0] st_reg;
  reg [3:0] seq_reg;
  reg [7:0] tmr_reg;
  reg [11:0] cnt_reg;
  reg dly_busy_reg;
  reg pre_reg;
  reg init_reg;
  reg [2:0] op_reg;
  reg [BLK_W-1:0] blk_reg;
  reg [5:0] page_reg;
  reg [11:0] col_reg;
  reg [11:0] len_reg;
  reg [7:0] stat_reg;
  reg pop_reg;
  reg bad_set_reg;
  reg [BLK_W-1:0] bad_idx_reg;
  reg [BLOCKS-1:0] bad_reg;
  reg pg_valid_reg;
  reg [BLK_W-1:0] pg_blk_reg;
  reg [5:0] pg_last_reg;
  reg [2:0] pg_cnt_reg;
  reg [7:0] addr_byte;
  reg [7:0] c1_code;
  reg [7:0] c2_code;
  reg refuse;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire [23:0] row;
  wire is_pe;
  wire cmd_pe;

  nfc_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop_reg),
    .out_data(fifo_data)
  );

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n <= rs1_reg;
    end
  end

  // Bad block table, one flip-flop per block
  genvar gi;
  generate
    for (gi = 0; gi < BLOCKS; gi = gi + 1) begin : g_bad
      localparam [BLK_W-1:0] IDX = gi;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bad_reg[gi] <= 1'b0;
        end else if (bad_set_reg && bad_idx_reg == IDX) begin
          bad_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Block and page need more than two row bytes; third row cycle used
  assign row = {{(24-BLK_W-6){1'b0}}, blk_reg, page_reg};
  assign is_pe = (op_reg == `NFC_OP_PROG) || (op_reg == `NFC_OP_ERASE);
  assign cmd_pe = (cmd_op == `NFC_OP_PROG) || (cmd_op == `NFC_OP_ERASE);

  always @* begin
    case (cnt_reg[2:0])
      3'h0: addr_byte = col_reg[7:0];
      3'h1: addr_byte = {4'h0, col_reg[11:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      3'h4: addr_byte = row[23:16];
      default: addr_byte = 8'h00;
    endcase
    case (op_reg)
      `NFC_OP_RESET: c1_code = `NFC_CMD_RESET;
      `NFC_OP_PROG: c1_code = `NFC_CMD_PROG1;
      `NFC_OP_ERASE: c1_code = `NFC_CMD_ERASE1;
      default: c1_code = `NFC_CMD_READ1;
    endcase
    case (op_reg)
      `NFC_OP_PROG: c2_code = `NFC_CMD_PROG2;
      `NFC_OP_ERASE: c2_code = `NFC_CMD_ERASE2;
      default: c2_code = `NFC_CMD_READ2;
    endcase
    refuse = 1'b0;
    if (cmd_op > `NFC_OP_BADCHK) begin
      refuse = 1'b1;
    end
    if (cmd_pe && bad_reg[cmd_block]) begin
      refuse = 1'b1;
    end
    if ((cmd_op == `NFC_OP_PROG || cmd_op == `NFC_OP_READ) &&
        cmd_len == 12'h000) begin
      refuse = 1'b1;
    end
    if (cmd_op == `NFC_OP_PROG && pg_valid_reg &&
        cmd_block == pg_blk_reg) begin
      if (cmd_page < pg_last_reg) begin
        refuse = 1'b1;
      end
      if (cmd_page == pg_last_reg && pg_cnt_reg >= `NFC_PARTIAL_MAX) begin
        refuse = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_SEQ;
      seq_reg <= Q_C1;
      tmr_reg <= 8'h00;
      cnt_reg <= 12'h000;
      dly_busy_reg <= 1'b0;
      pre_reg <= 1'b0;
      init_reg <= 1'b1;
      op_reg <= `NFC_OP_RESET;
      blk_reg <= {BLK_W{1'b0}};
      page_reg <= 6'h00;
      col_reg <= 12'h000;
      len_reg <= 12'h000;
      stat_reg <= 8'h00;
      pop_reg <= 1'b0;
      bad_set_reg <= 1'b0;
      bad_idx_reg <= {BLK_W{1'b0}};
      pg_valid_reg <= 1'b0;
      pg_blk_reg <= {BLK_W{1'b0}};
      pg_last_reg <= 6'h00;
      pg_cnt_reg <= 3'h0;
      cmd_ready <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      rd_chunk_end <= 1'b0;
      done <= 1'b0;
      done_fail <= 1'b0;
      done_refused <= 1'b0;
      done_status <= 8'h00;
      block_bad <= 1'b0;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      output_strobe_n <= 1'b1;
      wp_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      pop_reg <= 1'b0;
      bad_set_reg <= 1'b0;
      rd_valid <= 1'b0;
      rd_chunk_end <= 1'b0;
      done <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          ce_n <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            if (refuse) begin
              done <= 1'b1;
              done_fail <= 1'b0;
              done_refused <= 1'b1;
            end else begin
              cmd_ready <= 1'b0;
              ce_n <= 1'b0;
              op_reg <= cmd_op;
              blk_reg <= cmd_block;
              page_reg <= cmd_page;
              col_reg <= cmd_col;
              len_reg <= (cmd_op == `NFC_OP_BADCHK) ? 12'h001 : cmd_len;
              if (cmd_op == `NFC_OP_STATUS) begin
                seq_reg <= Q_SC;
                st_reg <= ST_SEQ;
              end else if (cmd_op == `NFC_OP_RESET) begin
                seq_reg <= Q_C1;
                st_reg <= ST_SEQ;
              end else begin
                // Write-protect setup time before the first latch
                wp_n <= cmd_pe;
                pre_reg <= 1'b1;
                dly_busy_reg <= 1'b1;
                tmr_reg <= TWW - 8'h01;
                st_reg <= ST_DLY;
              end
            end
          end
        end
        ST_SEQ: begin
          ce_n <= 1'b0;
          case (seq_reg)
            Q_C1: begin
              io_out <= c1_code;
              io_oe <= 1'b1;
              cle <= 1'b1;
              we_n <= 1'b0;
              tmr_reg <= WLO - 8'h01;
              st_reg <= ST_WLO;
              if (op_reg == `NFC_OP_RESET) begin
                seq_reg <= Q_BSY;
              end else begin
                seq_reg <= Q_AD;
                cnt_reg <= (op_reg == `NFC_OP_ERASE) ?
                  {9'h000, `NFC_ROW_FIRST} : 12'h000;
              end
            end
            Q_AD: begin
              io_out <= addr_byte;
              io_oe <= 1'b1;
              ale <= 1'b1;
              we_n <= 1'b0;
              tmr_reg <= WLO - 8'h01;
              st_reg <= ST_WLO;
              cnt_reg <= cnt_reg + 12'h001;
              if (cnt_reg[2:0] == `NFC_ADDR_CYCLES - 3'h1) begin
                cnt_reg <= 12'h000;
                seq_reg <= (op_reg == `NFC_OP_PROG) ? Q_WD : Q_C2;
              end
            end
            Q_WD: begin
              // Stalls here while the FIFO is empty
              if (fifo_valid) begin
                pop_reg <= 1'b1;
                io_out <= fifo_data;
                io_oe <= 1'b1;
                we_n <= 1'b0;
                tmr_reg <= WLO - 8'h01;
                st_reg <= ST_WLO;
                cnt_reg <= cnt_reg + 12'h001;
                if (cnt_reg == len_reg - 12'h001) begin
                  seq_reg <= Q_C2;
                end
              end
            end
            Q_C2: begin
              io_out <= c2_code;
              io_oe <= 1'b1;
              cle <= 1'b1;
              we_n <= 1'b0;
              tmr_reg <= WLO - 8'h01;
              st_reg <= ST_WLO;
              seq_reg <= Q_BSY;
            end
            Q_BSY: begin
              // Busy only shows after the write-to-busy delay
              pre_reg <= 1'b0;
              dly_busy_reg <= 1'b1;
              tmr_reg <= TWB - 8'h01;
              st_reg <= ST_DLY;
            end
            Q_SC: begin
              io_out <= `NFC_CMD_STATUS;
              io_oe <= 1'b1;
              cle <= 1'b1;
              we_n <= 1'b0;
              tmr_reg <= WLO - 8'h01;
              st_reg <= ST_WLO;
              seq_reg <= Q_SR;
            end
            Q_SR, Q_RD: begin
              output_strobe_n <= 1'b0;
              tmr_reg <= RLO - 8'h01;
              st_reg <= ST_RLO;
            end
            default: begin
              cmd_ready <= 1'b1;
              wp_n <= 1'b0;
              st_reg <= ST_IDLE;
              init_reg <= 1'b0;
              cnt_reg <= 12'h000;
              if (!init_reg) begin
                done <= 1'b1;
                done_refused <= 1'b0;
                done_status <= stat_reg;
                done_fail <= is_pe && stat_reg[`NFC_ST_FAIL_BIT];
              end
              if (is_pe && stat_reg[`NFC_ST_FAIL_BIT]) begin
                bad_set_reg <= 1'b1;
                bad_idx_reg <= blk_reg;
              end
              if (op_reg == `NFC_OP_PROG) begin
                pg_valid_reg <= 1'b1;
                pg_blk_reg <= blk_reg;
                pg_last_reg <= page_reg;
                pg_cnt_reg <= (pg_valid_reg && blk_reg == pg_blk_reg &&
                  page_reg == pg_last_reg) ? pg_cnt_reg + 3'h1 : 3'h1;
              end
              if (op_reg == `NFC_OP_ERASE && blk_reg == pg_blk_reg) begin
                pg_valid_reg <= 1'b0;
              end
            end
          endcase
        end
        ST_WLO: begin
          if (tmr_reg != 8'h00) begin
            tmr_reg <= tmr_reg - 8'h01;
          end else begin
            we_n <= 1'b1;
            tmr_reg <= WHI - 8'h01;
            st_reg <= ST_WHI;
          end
        end
        ST_WHI: begin
          if (tmr_reg != 8'h00) begin
            tmr_reg <= tmr_reg - 8'h01;
          end else begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            st_reg <= ST_SEQ;
          end
        end
        ST_RLO: begin
          if (tmr_reg != 8'h00) begin
            tmr_reg <= tmr_reg - 8'h01;
          end else begin
            output_strobe_n <= 1'b1;
            tmr_reg <= RHI - 8'h01;
            st_reg <= ST_RHI;
            if (seq_reg == Q_SR) begin
              stat_reg <= io_in;
              seq_reg <= Q_FIN;
            end else begin
              cnt_reg <= cnt_reg + 12'h001;
              if (cnt_reg == len_reg - 12'h001) begin
                seq_reg <= Q_FIN;
              end
              if (op_reg == `NFC_OP_BADCHK) begin
                block_bad <= (io_in == `NFC_BAD_MARK);
                bad_set_reg <= (io_in == `NFC_BAD_MARK);
                bad_idx_reg <= blk_reg;
              end else begin
                rd_data <= io_in;
                rd_valid <= 1'b1;
                rd_chunk_end <= (cnt_reg[8:0] == `NFC_ECC_MASK) ||
                  (cnt_reg == len_reg - 12'h001);
              end
            end
          end
        end
        ST_RHI: begin
          if (tmr_reg != 8'h00) begin
            tmr_reg <= tmr_reg - 8'h01;
          end else begin
            st_reg <= ST_SEQ;
          end
        end
        ST_DLY: begin
          if (tmr_reg != 8'h00) begin
            tmr_reg <= tmr_reg - 8'h01;
          end else if (dly_busy_reg) begin
            st_reg <= ST_BUSY;
          end else begin
            st_reg <= ST_SEQ;
          end
        end
        default: begin
          // Open-drain line: low while the device works
          if (ready_busy_out) begin
            st_reg <= ST_SEQ;
            if (pre_reg) begin
              pre_reg <= 1'b0;
              seq_reg <= Q_C1;
            end else if (is_pe) begin
              seq_reg <= Q_SC;
            end else if (op_reg == `NFC_OP_RESET) begin
              stat_reg <= 8'h00;
              seq_reg <= Q_FIN;
            end else begin
              cnt_reg <= 12'h000;
              seq_reg <= Q_RD;
            end
          end
        end
      endcase
    end
  end
endmodule // nfc_host

// ==== tb/nfc_host_asserts.sv ====
// Assertions on the NAND host pins and user handshake.
// Assumes binding into nfc_host; sees only its ports.
module nfc_host_asserts (
  input wire clk,
  input wire nrst,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire done,
  input wire done_fail,
  input wire done_refused,
  input wire [7:0] done_status,
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire output_strobe_n,
  input wire wp_n,
  input wire [7:0] io_out,
  input wire io_oe,
  input wire ready_busy_out
);
  logic we_q, prog_open, need_st, st_mode;
  logic [2:0] addr_cnt;
  wire lat = !ce_n && we_n && !we_q;
  wire cmd_lat = lat && cle;
  wire addr_lat = lat && ale;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      we_q <= 1'b1;
      prog_open <= 1'b0;
      need_st <= 1'b0;
      st_mode <= 1'b0;
      addr_cnt <= 3'h0;
    end else begin
      we_q <= we_n;
      if (cmd_lat) begin
        prog_open <= io_out == 8'h80;
        need_st <= io_out == 8'h10 || io_out == 8'hd0 ||
          (need_st && io_out != 8'h70);
        st_mode <= io_out == 8'h70;
        addr_cnt <= 3'h0;
      end else if (addr_lat && addr_cnt != 3'h7) begin
        addr_cnt <= addr_cnt + 3'h1;
      end
    end
  end
  sequence s_req_bad;
    cmd_valid && cmd_ready && cmd_op > 3'h5;
  endsequence
  sequence s_refused;
    done && done_refused && cmd_ready;
  endsequence
  a_refuse_op: assert property (s_req_bad |=> s_refused)
    else $error("bad op not refused");
  a_cmd_defined: assert property (cmd_lat |-> io_out inside
    {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hd0, 8'h70, 8'hff})
    else $error("undefined command");
  a_busy_cmds: assert property (cmd_lat
    && !$past(ready_busy_out, 3) |-> io_out inside {8'h70, 8'h71, 8'hff})
    else $error("command while busy");
  a_after_prog: assert property (cmd_lat && prog_open
    |-> io_out inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hff})
    else $error("bad command after 80");
  a_addr_max: assert property (addr_lat |-> addr_cnt < 3'h5)
    else $error("sixth address cycle");
  a_status_due: assert property (done |-> !need_st)
    else $error("no status read");
  a_wp_idle: assert property (cmd_ready && $past(cmd_ready) |-> !wp_n)
    else $error("wp high while idle");
  a_fail_bit: assert property (done && done_fail |-> done_status[0])
    else $error("fail without status bit");
  a_strobe_bus: assert property (!output_strobe_n |-> !io_oe && we_n)
    else $error("bus clash on read");
  a_read_ready: assert property ($fell(output_strobe_n)
    |-> ready_busy_out || st_mode)
    else $error("array read while busy");
endmodule // nfc_host_asserts

bind nfc_host nfc_host_asserts i_chk (.clk, .nrst, .cmd_valid, .cmd_ready,
  .cmd_op, .done, .done_fail, .done_refused, .done_status, .ce_n, .cle,
  .ale, .we_n, .output_strobe_n, .wp_n, .io_out, .io_oe, .ready_busy_out);

// ==== tb/nfc_flash_model.sv ====
// Behavioural NAND device on the host pins, bench use only.
// Assumes the host latches on the rising write strobe.
module nfc_flash_model #(
  parameter BUSY = 40,
  parameter BAD_BLK = 9 // Marked block, and block 1033 that aliases it (block bit 10 falls in the ignored fifth cycle); all others usable
) (
  input wire clk,
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire output_strobe_n,
  input wire wp_n,
  input wire [7:0] io_out,
  input wire fail_next,
  output logic [7:0] io_in,
  output wire ready_busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pbuf [0:15];
  logic [11:0] col;
  logic [15:0] row;
  logic smode = 1'b0, pend = 1'b0, fail = 1'b0, pe_run = 1'b0;
  int acnt, pidx;
  int bcnt = 60; // Power-up initialisation busy
  // Open drain with pull-up: high once released
  assign ready_busy_out = bcnt == 0;
  initial io_in = 8'h55;
  always @(posedge clk) begin
    if (bcnt > 0) bcnt <= bcnt - 1;
    else pe_run <= 1'b0;
  end
  // Busy updates by NBA so they land after the clocked countdown
  always @(negedge wp_n) if (pe_run) bcnt <= 0;
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      if (io_out != 8'h10) pend = 1'b0;
      case (io_out)
        8'hff: begin
          smode = 1'b0;
          // Never cuts the power-up busy short
          bcnt <= (bcnt > 5) ? bcnt : 5;
        end
        8'h70: smode = 1'b1;
        8'h00: begin
          smode = 1'b0;
          acnt = 0;
        end
        8'h30: bcnt <= BUSY;
        8'h80: begin
          pend = 1'b1;
          acnt = 0;
          pidx = 0;
        end
        8'h10: if (pend) begin
          pend = 1'b0;
          fail = fail_next;
          pe_run <= 1'b1;
          bcnt <= BUSY;
        end
        8'h60: acnt = 2;
        8'hd0: begin
          fail = 1'b0;
          pe_run <= 1'b1;
          bcnt <= BUSY;
        end
        default: ;
      endcase
    end else if (!ce_n && ale) begin
      case (acnt)
        0: col[7:0] = io_out;
        1: col[11:8] = io_out[3:0];
        2: row[7:0] = io_out;
        3: row[15:8] = io_out;
        default: ; // Fifth and any sixth cycle ignored
      endcase
      acnt++;
    end else if (!ce_n && pend) begin
      pbuf[pidx[3:0]] = io_out;
      pidx++;
    end
  end
  always @(negedge output_strobe_n) begin
    if (smode) io_in = {wp_n, 2'b11, 4'h0, fail};
    else if (row[15:6] == BAD_BLK && col == 12'h0) io_in = 8'h00;
    else io_in = col[7:0] ^ row[7:0] ^ 8'ha5;
    if (!smode) col = col + 12'h1;
  end
  // Released bus shows the inverse, never a stale byte
  always @(posedge output_strobe_n) io_in = ~io_in;
endmodule // nfc_flash_model

// ==== tb/nfc_host_tb.sv ====
// Self-checking bench of nfc_host against the flash model.
// Assumes a 100 MHz clock; inputs change 1 ns after the edge.
module nfc_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, cmd_valid, wr_valid, fail_next, rd_on;
  logic [2:0] cmd_op;
  logic [10:0] cmd_block;
  logic [5:0] cmd_page;
  logic [11:0] cmd_col, cmd_len;
  logic [7:0] wr_data, rd_key;
  wire cmd_ready, wr_ready, rd_valid, rd_chunk_end, done, done_fail;
  wire done_refused, block_bad, ce_n, cle, ale, we_n, output_strobe_n;
  wire wp_n, io_oe, ready_busy_out;
  wire [7:0] rd_data, done_status, io_out, io_in;
  int n_fail, tests_run, cyc, rd_n;
  nfc_host i_dut (.clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_block,
    .cmd_page, .cmd_col, .cmd_len, .wr_data, .wr_valid, .wr_ready, .rd_data,
    .rd_valid, .rd_chunk_end, .done, .done_fail, .done_refused, .done_status,
    .block_bad, .ce_n, .cle, .ale, .we_n, .output_strobe_n, .wp_n, .io_out,
    .io_oe, .io_in, .ready_busy_out);
  nfc_flash_model i_flash (.clk, .ce_n, .cle, .ale, .we_n, .output_strobe_n,
    .wp_n, .io_out, .fail_next, .io_in, .ready_busy_out);
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input [2:0] op, input [10:0] blk, input [5:0] pg,
                     input [11:0] col, input [11:0] len);
    int k;
    cmd_op = op;
    cmd_block = blk;
    cmd_page = pg;
    cmd_col = col;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge clk);
    for (k = 0; k < 3000 && cmd_ready !== 1'b1; k++) @(posedge clk);
    #1 cmd_valid = 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("done", 1, done);
    // Let an edge pass so a following request never re-raises at once
    @(posedge clk);
    #1;
  endtask
  task automatic push(input int n, input [7:0] base);
    wr_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      wr_data = base + i[7:0];
      @(posedge clk);
      #1;
    end
    wr_valid = 1'b0;
  endtask
  always @(posedge clk) begin
    if (rd_on && rd_valid === 1'b1) begin
      chk("rd_data", rd_key ^ rd_n[7:0], rd_data);
      chk("chunk_end", rd_n == 511 || rd_n == 513, rd_chunk_end);
      rd_n <= rd_n + 1;
    end
  end
  task automatic t_init;
    for (int k = 0; k < 2000 && cmd_ready !== 1'b1; k++) @(posedge clk);
    #1;
    chk("init_ready", 1, cmd_ready);
    chk("init_wait", 1, cyc > 60);
  endtask
  task automatic t_status;
    run(3'h1, 11'd0, 6'd0, 12'h0, 12'h0);
    chk("status", 8'h60, done_status);
    run(3'h0, 11'd0, 6'd0, 12'h0, 12'h0);
    chk("reset_ok", 0, done_refused);
  endtask
  task automatic t_refuse;
    for (int op = 6; op < 8; op++) begin
      run(op[2:0], 11'd3, 6'd0, 12'h0, 12'd1);
      chk("bad_op", 1, done_refused);
    end
    run(3'h2, 11'd3, 6'd0, 12'h0, 12'h0);
    chk("len_zero", 1, done_refused);
  endtask
  task automatic t_read;
    rd_on = 1'b1;
    rd_n = 0;
    rd_key = 8'ha5 ^ {2'b11, 6'd1};
    run(3'h2, 11'd3, 6'd1, 12'h0, 12'd514);
    repeat (2) @(posedge clk);
    #1 rd_on = 1'b0;
    chk("rd_count", 514, rd_n);
  endtask
  task automatic t_prog;
    push(16, 8'h30);
    chk("fifo_full", 0, wr_ready);
    run(3'h3, 11'd5, 6'd2, 12'h0, 12'd16);
    chk("prog_fail", 0, done_fail);
    for (int i = 0; i < 16; i++) chk("prog_byte", 8'h30 + i, i_flash.pbuf[i]);
    chk("fifo_empty", 1, wr_ready);
    run(3'h3, 11'd5, 6'd1, 12'h0, 12'd1);
    chk("page_order", 1, done_refused);
    for (int i = 0; i < 4; i++) begin
      if (i < 3) push(1, 8'h40);
      run(3'h3, 11'd5, 6'd2, 12'h10, 12'd1);
      chk("partial", i == 3, done_refused);
    end
  endtask
  task automatic t_fail;
    fail_next = 1'b1;
    push(1, 8'h77);
    run(3'h3, 11'd7, 6'd0, 12'h0, 12'd1);
    fail_next = 1'b0;
    chk("fail_flag", 1, done_fail);
    chk("fail_bit", 1, done_status[0]);
    run(3'h4, 11'd7, 6'd0, 12'h0, 12'h0);
    chk("fenced", 1, done_refused);
  endtask
  task automatic t_bad;
    run(3'h5, 11'd9, 6'd1, 12'h0, 12'd1);
    chk("bad_found", 1, block_bad);
    run(3'h4, 11'd9, 6'd0, 12'h0, 12'h0);
    chk("bad_erase", 1, done_refused);
    run(3'h5, 11'd4, 6'd1, 12'h0, 12'd1);
    chk("good_found", 0, block_bad);
    run(3'h4, 11'd4, 6'd0, 12'h0, 12'h0);
    chk("erase_ok", 0, done_refused);
    chk("erase_pass", 0, done_fail);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_block = 11'h0;
    cmd_page = 6'h0;
    cmd_col = 12'h0;
    cmd_len = 12'h0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    fail_next = 1'b0;
    rd_on = 1'b0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    t_init;
    t_status;
    t_refuse;
    t_read;
    t_prog;
    t_fail;
    t_bad;
    tally_and_finish;
  end
endmodule // nfc_host_tb
